// ### hdl/bfdp_protect_top.sv
// Fault-input conditioning and per-channel output protection with Avalon-MM registers
`timescale 1ns/1ps
`default_nettype none
`include "bfdp_consts.svh"
// Function
// RULE1 - Enable bit 24 gates fault input 0
// RULE2 - Enable and filter writes need lock 00
// RULE3 - Four-bit filter field per fault input
// RULE4 - Output changes after N consecutive samples
// RULE5 - Code 0000 passes input unfiltered
// RULE6 - Codes 1-3 sample at kernel clock
// RULE7 - Codes 4-9 sample dts/2,/4,/8
// RULE8 - Codes A-F sample dts/16 and /32
// RULE9 - Bit 31 selects local or shared settings
// RULE10 - Select and dead-time writable at lock 00
// RULE11 - Run off-state bit gates pair when enabled
// RULE12 - Idle off-state bit gates pair otherwise
// RULE13 - Off-state bits locked at levels 10, 11
// RULE14 - Dead-time inserted before each pair transition
// RULE15 - Code 0xx: value times one dts period
// RULE16 - Code 10x: 64 plus low six, x2
// RULE17 - Code 110: 32 plus low five, x8
// RULE18 - Code 111: 32 plus low five, x16
// RULE19 - Channel registers at 0x7C, 0x80, reset zero
// RULE20 - Software uses whole-word accesses only
// RULE21 - Software writes reserved bits with reset value
// RULE22 - Polarity bit: 0 active low, 1 high
// RULE23 - Filtered inputs synchronised to kernel clock
// RULE24 - Filter code change restarts event counter
module bfdp_protect_top
  import bfdp_pkg::*;
#(
  parameter int DTS_DIV = 1
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        reset_n,
  // Avalon-MM slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  input  wire logic [3:0]  byteenable,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  output logic [1:0]       response,
  // Fault pins
  input  wire logic [3:0]  faultInput,
  output logic [3:0]       faultActive,
  // Channel references
  input  wire logic [1:0]  chanRef,
  // Output pairs
  output logic [1:0]       chanMainOut,
  output logic [1:0]       chanCompOut
);
  initial begin
    if (DTS_DIV < 1 || DTS_DIV > 255) begin
      $error("DTS_DIV out of range");
    end
  end

  logic [31:0] breakCfg_q;
  logic [31:0] chanProt_q [2];
  logic [31:0] shared_q;
  logic [31:0] chanCtl_q;
  logic        done_q;
  logic [7:0]  dtsCnt_q;
  logic        dtsTick_q;
  logic [4:0]  divCnt_q;
  logic [4:0]  divPulse_q;
  logic [3:0]  faultRaw;
  logic [1:0]  pairMain;
  logic [1:0]  pairComp;
  logic        accept;
  logic        commit;
  logic        fullWord;
  bfdp_lock_t  lockLevel;
  logic        primaryEn;
  logic        lockFree;
  logic        offStateFree;
  logic        validAddr;

  assign lockLevel    = shared_q[`BFDP_LOCK_LSB +: 2];
  assign primaryEn    = shared_q[`BFDP_PRIMARY_OUTPUT_ENABLE_BIT];
  assign lockFree     = (lockLevel == 2'b00);
  assign offStateFree = ~lockLevel[1];
  assign accept       = (read | write) & ~done_q;
  // Writes land on the edge after the wait cycle, while waitrequest is low
  assign commit       = write & done_q;
  // RULE20 only whole-word writes take effect
  assign fullWord     = (byteenable == 4'hF);
  assign validAddr    = (address == `BFDP_OFF_BRKCFG) | (address == `BFDP_OFF_PROT0) |
                        (address == `BFDP_OFF_PROT1) | (address == `BFDP_OFF_SHARED) |
                        (address == `BFDP_OFF_CHCTL) | (address == `BFDP_OFF_STATUS);

  // Dead-time clock enable from kernel clock
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      dtsCnt_q  <= 8'h00;
      dtsTick_q <= 1'b0;
    end else if (dtsCnt_q == 8'(DTS_DIV - 1)) begin
      dtsCnt_q  <= 8'h00;
      dtsTick_q <= 1'b1;
    end else begin
      dtsCnt_q  <= dtsCnt_q + 8'h01;
      dtsTick_q <= 1'b0;
    end
  end

  // RULE7 RULE8 dts sub-rate enables
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      divCnt_q   <= 5'h00;
      divPulse_q <= 5'h00;
    end else begin
      divPulse_q <= 5'h00;
      if (dtsTick_q) begin
        divCnt_q      <= divCnt_q + 5'h01;
        divPulse_q[0] <= (divCnt_q[0] == 1'b1);
        divPulse_q[1] <= (divCnt_q[1:0] == 2'h3);
        divPulse_q[2] <= (divCnt_q[2:0] == 3'h7);
        divPulse_q[3] <= (divCnt_q[3:0] == 4'hF);
        divPulse_q[4] <= (divCnt_q == 5'h1F);
      end
    end
  end

  // Bus handshake: one wait cycle per access
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      done_q <= 1'b0;
    end else begin
      done_q <= accept;
    end
  end

  always_comb begin
    waitrequest = (read | write) & ~done_q;
  end

  // RULE2 RULE21 fault configuration, lock 00 only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      breakCfg_q <= `BFDP_BRKCFG_RST;
    end else if (commit && fullWord && address == `BFDP_OFF_BRKCFG && lockFree) begin
      breakCfg_q <= writedata & `BFDP_BRKCFG_MASK;
    end
  end

  // RULE19 per-channel protection registers
  for (genvar c = 0; c < 2; c++) begin : g_chan
    logic hit;
    assign hit = commit & fullWord &
                 (address == ((c == 0) ? `BFDP_OFF_PROT0 : `BFDP_OFF_PROT1));
    always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
        chanProt_q[c] <= `BFDP_WRITE_LOCK_LEVEL_RST;
      end else if (hit) begin
        // RULE10 select and dead-time at lock 00
        if (lockFree) begin
          chanProt_q[c][`BFDP_SEL_BIT] <= writedata[`BFDP_SEL_BIT];
          chanProt_q[c][7:0]           <= writedata[7:0];
        end
        // RULE13 off-state bits locked at 10, 11
        if (offStateFree) begin
          chanProt_q[c][`BFDP_ROS_BIT] <= writedata[`BFDP_ROS_BIT];
          chanProt_q[c][`BFDP_IOS_BIT] <= writedata[`BFDP_IOS_BIT];
        end
      end
    end
  end

  // Shared protection stand-in: lock field rises only
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      shared_q <= `BFDP_SHARED_RST;
    end else if (commit && fullWord && address == `BFDP_OFF_SHARED) begin
      shared_q[`BFDP_PRIMARY_OUTPUT_ENABLE_BIT] <= writedata[`BFDP_PRIMARY_OUTPUT_ENABLE_BIT];
      if (lockFree) begin
        shared_q[`BFDP_LOCK_LSB +: 2] <= writedata[`BFDP_LOCK_LSB +: 2];
        shared_q[7:0]                 <= writedata[7:0];
      end
      if (offStateFree) begin
        shared_q[`BFDP_ROS_BIT] <= writedata[`BFDP_ROS_BIT];
        shared_q[`BFDP_IOS_BIT] <= writedata[`BFDP_IOS_BIT];
      end
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chanCtl_q <= `BFDP_CHCTL_RST;
    end else if (commit && fullWord && address == `BFDP_OFF_CHCTL) begin
      chanCtl_q <= writedata & `BFDP_CHCTL_MASK;
    end
  end

  // Read data and response
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= 32'h0000_0000;
      response <= 2'h0;
    end else if (accept) begin
      response <= validAddr ? 2'h0 : 2'h3;
      readdata <= 32'h0000_0000;
      if (read) begin
        unique case (address)
          `BFDP_OFF_BRKCFG: readdata <= breakCfg_q;
          `BFDP_OFF_PROT0:  readdata <= chanProt_q[0];
          `BFDP_OFF_PROT1:  readdata <= chanProt_q[1];
          `BFDP_OFF_SHARED: readdata <= shared_q;
          `BFDP_OFF_CHCTL:  readdata <= chanCtl_q;
          `BFDP_OFF_STATUS: readdata <= {24'h0, chanCompOut, chanMainOut, faultActive};
          default:          readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // RULE3 per-input filter fields
  for (genvar i = 0; i < 4; i++) begin : g_fault
    bfdp_fault_filter u_filter (
      .core_clk    (core_clk),
      .reset_n     (reset_n),
      .faultPin    (faultInput[i]),
      .enable      (breakCfg_q[`BFDP_BRK_EN_BIT + 2 * i]),
      .polarity    (breakCfg_q[`BFDP_BRK_POL_BIT + 2 * i]),
      .filterCode  (breakCfg_q[4 * i +: 4]),
      .dtsDiv2     (divPulse_q[0]),
      .dtsDiv4     (divPulse_q[1]),
      .dtsDiv8     (divPulse_q[2]),
      .dtsDiv16    (divPulse_q[3]),
      .dtsDiv32    (divPulse_q[4]),
      .faultActive (faultRaw[i])
    );
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      faultActive <= 4'h0;
    end else begin
      faultActive <= faultRaw;
    end
  end

  for (genvar c = 0; c < 2; c++) begin : g_pair
    logic       useLocal;
    logic [7:0] dtCode;
    logic       runOff;
    logic       idleOff;
    logic       pairOn;
    // RULE9 local or shared settings
    assign useLocal = chanProt_q[c][`BFDP_SEL_BIT];
    assign dtCode   = useLocal ? chanProt_q[c][7:0] : shared_q[7:0];
    assign runOff   = useLocal ? chanProt_q[c][`BFDP_ROS_BIT] : shared_q[`BFDP_ROS_BIT];
    assign idleOff  = useLocal ? chanProt_q[c][`BFDP_IOS_BIT] : shared_q[`BFDP_IOS_BIT];
    // RULE11 RULE12 off-state gating by primary enable
    assign pairOn   = primaryEn ? runOff : idleOff;

    bfdp_deadtime_gen u_dt (
      .core_clk     (core_clk),
      .reset_n      (reset_n),
      .dtsTick      (dtsTick_q),
      .deadtimeCode (dtCode),
      .refWave      (chanRef[c]),
      .outEnable    (pairOn),
      .mainEnable   (chanCtl_q[2 * c]),
      .compEnable   (chanCtl_q[2 * c + 1]),
      .mainOut      (pairMain[c]),
      .compOut      (pairComp[c])
    );
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      chanMainOut <= 2'h0;
      chanCompOut <= 2'h0;
    end else begin
      chanMainOut <= pairMain;
      chanCompOut <= pairComp;
    end
  end
endmodule : bfdp_protect_top
`default_nettype wire

// ### hdl/bfdp_consts.svh
// Offsets, field positions, reset values and write masks of the fault-filter and dead-time block
`ifndef BFDP_CONSTS_SVH
`define BFDP_CONSTS_SVH
`define BFDP_OFF_BRKCFG    8'h78
`define BFDP_OFF_PROT0     8'h7C
`define BFDP_OFF_PROT1     8'h80
`define BFDP_OFF_SHARED    8'h84
`define BFDP_OFF_CHCTL     8'h88
`define BFDP_OFF_STATUS    8'h8C
`define BFDP_BRKCFG_RST    32'h0000_0000
`define BFDP_WRITE_LOCK_LEVEL_RST      32'h0000_0000
`define BFDP_SHARED_RST    32'h0000_0000
`define BFDP_CHCTL_RST     32'h0000_0000
`define BFDP_BRK_EN_BIT    24
`define BFDP_BRK_POL_BIT   25
`define BFDP_SEL_BIT       31
`define BFDP_ROS_BIT       11
`define BFDP_IOS_BIT       10
`define BFDP_LOCK_LSB      8
`define BFDP_PRIMARY_OUTPUT_ENABLE_BIT      15
`define BFDP_BRKCFG_MASK   32'hFF00_FFFF
`define BFDP_WRITE_LOCK_LEVEL_MASK     32'h8000_0CFF
`define BFDP_SHARED_MASK   32'h0000_8FFF
`define BFDP_CHCTL_MASK    32'h0000_000F
`endif

// ### hdl/bfdp_pkg.sv
// Types shared by the fault-filter and dead-time block
package bfdp_pkg;
  typedef logic [1:0] bfdp_lock_t;
  typedef enum logic [2:0] {
    BFDP_DT_IDLE = 3'b001,
    BFDP_DT_WAIT = 3'b010,
    BFDP_DT_DRIVE = 3'b100
  } bfdp_dt_state_e;
endpackage : bfdp_pkg

// ### hdl/bfdp_fault_filter.sv
// One fault input: synchroniser, polarity, sample-rate and event-count filter
`timescale 1ns/1ps
`default_nettype none
module bfdp_fault_filter
  import bfdp_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Pin and configuration
  input  wire logic       faultPin,
  input  wire logic       enable,
  input  wire logic       polarity,
  input  wire logic [3:0] filterCode,
  // Sample-rate enables
  input  wire logic       dtsDiv2,
  input  wire logic       dtsDiv4,
  input  wire logic       dtsDiv8,
  input  wire logic       dtsDiv16,
  input  wire logic       dtsDiv32,
  // Result
  output logic            faultActive
);
  logic       syncA_q;
  logic       syncB_q;
  logic       level_q;
  logic [3:0] count_q;
  logic [3:0] codeSeen_q;
  logic       sampleEn;
  logic [3:0] needed;
  logic       activeIn;
  logic       asyncAct;

  // RULE23 two-stage synchroniser
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      syncA_q <= 1'b0;
      syncB_q <= 1'b0;
    end else begin
      syncA_q <= faultPin;
      syncB_q <= syncA_q;
    end
  end

  // RULE22 polarity select
  assign activeIn = polarity ? syncB_q : ~syncB_q;
  // RULE5 raw pin path, unfiltered
  assign asyncAct = polarity ? faultPin : ~faultPin;

  // RULE6 RULE7 RULE8 rate and count table
  always_comb begin
    sampleEn = 1'b1;
    needed   = 4'h1;
    unique case (filterCode)
      4'h0: begin sampleEn = 1'b1;     needed = 4'h1; end
      4'h1: begin sampleEn = 1'b1;     needed = 4'h2; end
      4'h2: begin sampleEn = 1'b1;     needed = 4'h4; end
      4'h3: begin sampleEn = 1'b1;     needed = 4'h8; end
      4'h4: begin sampleEn = dtsDiv2;  needed = 4'h6; end
      4'h5: begin sampleEn = dtsDiv2;  needed = 4'h8; end
      4'h6: begin sampleEn = dtsDiv4;  needed = 4'h6; end
      4'h7: begin sampleEn = dtsDiv4;  needed = 4'h8; end
      4'h8: begin sampleEn = dtsDiv8;  needed = 4'h6; end
      4'h9: begin sampleEn = dtsDiv8;  needed = 4'h8; end
      4'hA: begin sampleEn = dtsDiv16; needed = 4'h5; end
      4'hB: begin sampleEn = dtsDiv16; needed = 4'h6; end
      4'hC: begin sampleEn = dtsDiv16; needed = 4'h8; end
      4'hD: begin sampleEn = dtsDiv32; needed = 4'h5; end
      4'hE: begin sampleEn = dtsDiv32; needed = 4'h6; end
      4'hF: begin sampleEn = dtsDiv32; needed = 4'h8; end
    endcase
  end

  // RULE4 consecutive-sample event counter
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      level_q    <= 1'b0;
      count_q    <= 4'h0;
      codeSeen_q <= 4'h0;
    end else begin
      codeSeen_q <= filterCode;
      // RULE24 restart on code change
      if (codeSeen_q != filterCode) begin
        count_q <= 4'h0;
      end else if (sampleEn) begin
        if (activeIn == level_q) begin
          count_q <= 4'h0;
        end else if (count_q + 4'h1 >= needed) begin
          level_q <= activeIn;
          count_q <= 4'h0;
        end else begin
          count_q <= count_q + 4'h1;
        end
      end
    end
  end

  // RULE1 enable gates the input
  assign faultActive = enable & ((filterCode == 4'h0) ? asyncAct : level_q);
endmodule : bfdp_fault_filter
`default_nettype wire

// ### hdl/bfdp_deadtime_gen.sv
// One complementary output pair: dead-time insertion and off-state gating
`timescale 1ns/1ps
`default_nettype none
module bfdp_deadtime_gen
  import bfdp_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       reset_n,
  // Timing
  input  wire logic       dtsTick,
  input  wire logic [7:0] deadtimeCode,
  // Control
  input  wire logic       refWave,
  input  wire logic       outEnable,
  input  wire logic       mainEnable,
  input  wire logic       compEnable,
  // Outputs
  output logic            mainOut,
  output logic            compOut
);
  bfdp_dt_state_e state_q;
  logic [11:0]    remain_q;
  logic [11:0]    dtTicks;
  logic           lastRef_q;

  // RULE15 RULE16 RULE17 RULE18 code to dts ticks
  always_comb begin
    if (!deadtimeCode[7]) begin
      dtTicks = {4'h0, deadtimeCode};
    end else if (!deadtimeCode[6]) begin
      dtTicks = 12'(({6'h0, deadtimeCode[5:0]} + 12'd64) << 1);
    end else if (!deadtimeCode[5]) begin
      dtTicks = 12'(({7'h0, deadtimeCode[4:0]} + 12'd32) << 3);
    end else begin
      dtTicks = 12'(({7'h0, deadtimeCode[4:0]} + 12'd32) << 4);
    end
  end

  // RULE14 dead-time before each transition
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q   <= BFDP_DT_IDLE;
      remain_q  <= 12'h000;
      lastRef_q <= 1'b0;
    end else begin
      lastRef_q <= refWave;
      unique case (state_q)
        BFDP_DT_IDLE: begin
          state_q <= BFDP_DT_WAIT;
          remain_q <= dtTicks;
        end
        BFDP_DT_WAIT: begin
          if (refWave != lastRef_q) begin
            remain_q <= dtTicks;
          end else if (remain_q == 12'h000) begin
            state_q <= BFDP_DT_DRIVE;
          end else if (dtsTick) begin
            remain_q <= remain_q - 12'h001;
          end
        end
        BFDP_DT_DRIVE: begin
          if (refWave != lastRef_q) begin
            state_q  <= BFDP_DT_WAIT;
            remain_q <= dtTicks;
          end
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mainOut <= 1'b0;
      compOut <= 1'b0;
    end else begin
      mainOut <= outEnable & mainEnable & (state_q == BFDP_DT_DRIVE) & lastRef_q;
      compOut <= outEnable & compEnable & (state_q == BFDP_DT_DRIVE) & ~lastRef_q;
    end
  end
endmodule : bfdp_deadtime_gen
`default_nettype wire

// ### bench/bfdp_protect_checker.sv
// Concurrent checks on the register port and the output pairs
`timescale 1ns/1ps
`default_nettype none
module bfdp_protect_checker (
  // Clock and reset
  input wire logic        core_clk,
  input wire logic        reset_n,
  // Avalon-MM slave
  input wire logic [7:0]  address,
  input wire logic        read,
  input wire logic        write,
  input wire logic [31:0] readdata,
  input wire logic        waitrequest,
  input wire logic [1:0]  response,
  // Output pairs
  input wire logic [1:0]  chanRef,
  input wire logic [1:0]  chanMainOut,
  input wire logic [1:0]  chanCompOut
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  logic acc;
  logic mapped;
  assign acc    = read || write;
  assign mapped = address inside {8'h78, 8'h7C, 8'h80, 8'h84, 8'h88, 8'h8C};
  property p_ack;
    acc && waitrequest |=> !waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer after one wait cycle");
  property p_idle;
    !acc |-> !waitrequest;
  endproperty
  a_idle: assert property (p_idle) else $error("wait raised with no request");
  property p_unm;
    acc && waitrequest && !mapped |=> response == 2'b11;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped access not flagged");
  property p_map;
    acc && waitrequest && mapped |=> response == 2'b00;
  endproperty
  a_map: assert property (p_map) else $error("mapped access flagged");
  property p_rd0;
    read && waitrequest && !mapped |=> readdata == 32'h0000_0000;
  endproperty
  a_rd0: assert property (p_rd0) else $error("unmapped read not zero");
  property p_hold;
    !acc [*2] |-> $stable(readdata) && $stable(response);
  endproperty
  a_hold: assert property (p_hold) else $error("answer changed while idle");
  property p_main;
    $rose(chanMainOut[0]) |-> $past(chanRef[0]);
  endproperty
  a_main: assert property (p_main) else $error("main output rose with reference low");
  property p_comp;
    $rose(chanCompOut[0]) |-> !$past(chanRef[0]);
  endproperty
  a_comp: assert property (p_comp) else $error("comp output rose with reference high");
  property p_excl;
    (chanMainOut & chanCompOut) == 2'b00;
  endproperty
  a_excl: assert property (p_excl) else $error("both outputs of a pair high");
endmodule : bfdp_protect_checker
bind bfdp_protect_top bfdp_protect_checker chk_u (
  .core_clk(core_clk), .reset_n(reset_n), .address(address), .read(read),
  .write(write), .readdata(readdata), .waitrequest(waitrequest),
  .response(response), .chanRef(chanRef), .chanMainOut(chanMainOut),
  .chanCompOut(chanCompOut)
);
`default_nettype wire

// ### bench/bfdp_power_stage.sv
// Far side model: fault sources and power-stage drivers
`timescale 1ns/1ps
`default_nettype none
module bfdp_power_stage (
  // Clock
  input  wire logic       core_clk,
  // Commanded levels
  input  wire logic [3:0] faultLvl,
  input  wire logic [1:0] refLvl,
  // Pins toward the block
  output logic [3:0]      faultInput,
  output logic [1:0]      chanRef,
  // Pair observation
  input  wire logic [1:0] chanMainOut,
  input  wire logic [1:0] chanCompOut,
  output logic            overlapSeen
);
  initial begin
    faultInput  = 4'h0;
    chanRef     = 2'h0;
    overlapSeen = 1'b0;
  end
  // Shoot-through would destroy the stage
  always @(posedge core_clk) begin
    faultInput <= faultLvl;
    chanRef    <= refLvl;
    if ((chanMainOut & chanCompOut) != 2'b00) overlapSeen <= 1'b1;
  end
endmodule : bfdp_power_stage
`default_nettype wire

// ### bench/break_filter_and_deadtime_protect_tb.sv
// Self-checking bench for fault filtering and output protection
`timescale 1ns/1ps
`default_nettype none
module break_filter_and_deadtime_protect_tb;
  logic        core_clk;
  logic        reset_n;
  logic [7:0]  address;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [1:0]  response;
  logic [3:0]  faultLvl;
  logic [3:0]  faultInput;
  logic [3:0]  faultActive;
  logic [1:0]  refLvl;
  logic [1:0]  chanRef;
  logic [1:0]  chanMainOut;
  logic [1:0]  chanCompOut;
  logic        overlapSeen;
  logic [31:0] rd;
  logic [31:0] cfg;
  logic [1:0]  rsp;
  logic        hit;
  int          num_errors;
  int          cmp_count;
  int          nTab [16] = '{1, 2, 4, 8, 6, 8, 6, 8, 6, 8, 5, 6, 8, 5, 6, 8};
  logic [7:0]  dtTab [4] = '{8'h05, 8'hA3, 8'hC1, 8'hE0};
  bfdp_protect_top #(.DTS_DIV(1)) dut_u (
    .core_clk(core_clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(4'hF), .readdata(readdata),
    .waitrequest(waitrequest), .response(response), .faultInput(faultInput),
    .faultActive(faultActive), .chanRef(chanRef), .chanMainOut(chanMainOut),
    .chanCompOut(chanCompOut)
  );
  bfdp_power_stage far_u (
    .core_clk(core_clk), .faultLvl(faultLvl), .refLvl(refLvl),
    .faultInput(faultInput), .chanRef(chanRef), .chanMainOut(chanMainOut),
    .chanCompOut(chanCompOut), .overlapSeen(overlapSeen)
  );
  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    address   <= a;
    writedata <= d;
    read      <= !wr;
    write     <= wr;
    @(posedge core_clk);
    while (waitrequest !== 1'b0 && n < 60) begin
      @(posedge core_clk);
      n++;
    end
    if (n == 60) num_errors++;
    @(posedge core_clk);
    rd  = readdata;
    rsp = response;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic run(input int cyc, input int i);
    repeat (cyc) begin
      @(posedge core_clk);
      hit |= faultActive[i];
    end
  endtask : run
  task automatic do_reset();
    reset_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    reset_n <= 1'b1;
  endtask : do_reset
  function automatic int samp(input int c);
    if (c < 4) return 1;
    if (c < 10) return 2 << ((c - 4) / 2);
    return (c < 13) ? 16 : 32;
  endfunction : samp
  function automatic int dtc(input logic [7:0] v);
    casez (v[7:5])
      3'b0??: return int'(v);
      3'b10?: return (64 + int'(v[5:0])) * 2;
      3'b110: return (32 + int'(v[4:0])) * 8;
      default: return (32 + int'(v[4:0])) * 16;
    endcase
  endfunction : dtc
  initial begin
    repeat (60000) @(posedge core_clk);
    num_errors++;
    give_verdict();
  end
  initial begin
    int i;
    int p;
    int nn;
    int n;
    logic pol;
    reset_n = 1'b0; address = 8'h00; read = 1'b0; write = 1'b0;
    writedata = 32'h0; faultLvl = 4'h0; refLvl = 2'h0; hit = 1'b0;
    do_reset();
    bus(1, 8'h80, 32'h8000_0CFF);
    bus(0, 8'h80, 32'h0);
    check(rd, 32'h8000_0CFF);
    $display("test regs finished");
    for (int c = 0; c < 16; c++) begin
      i = c % 4;
      pol = ((c / 4) % 2) == 1;
      p = samp(c);
      nn = nTab[c];
      cfg = ((32'(pol) << 1 | 32'h1) << (24 + 2 * i)) | (32'(c) << (4 * i));
      bus(1, 8'h78, cfg);
      faultLvl[i] <= !pol;
      run(nn * p + 8, i);
      check(faultActive[i], 1'b0);
      hit = 1'b0;
      if (c != 0) begin
        faultLvl[i] <= pol;
        run((nn - 1) * p, i);
        faultLvl[i] <= !pol;
        run(nn * p + 8, i);
      end
      check(hit, 1'b0);
      faultLvl[i] <= pol;
      run(nn * p + 8, i);
      check(faultActive[i], 1'b1);
      cfg = cfg & ~(32'h1 << (24 + 2 * i));
      bus(1, 8'h78, cfg);
      run(4, i);
      check(faultActive[i], 1'b0);
    end
    $display("test filter finished");
    bus(1, 8'h88, 32'h0000_000F);
    bus(1, 8'h84, 32'h0000_8000);
    for (int k = 0; k < 4; k++) begin
      bus(1, 8'h7C, 32'h8000_0800 | 32'(dtTab[k]));
      refLvl[0] <= 1'b0;
      repeat (dtc(dtTab[k]) + 8) @(posedge core_clk);
      refLvl[0] <= 1'b1;
      n = 0;
      while (chanMainOut[0] !== 1'b1 && n < 1100) begin
        @(negedge core_clk);
        n++;
      end
      check(32'(n >= dtc(dtTab[k]) + 2 && n <= dtc(dtTab[k]) + 6), 1);
      check(chanCompOut[0], 1'b0);
    end
    bus(1, 8'h7C, 32'h8000_0005);
    repeat (20) @(posedge core_clk);
    check({chanMainOut[0], chanCompOut[0]}, 2'b00);
    bus(1, 8'h84, 32'h0000_0000);
    bus(1, 8'h7C, 32'h8000_0405);
    repeat (20) @(posedge core_clk);
    check({chanMainOut[0], chanCompOut[0]}, 2'b10);
    bus(1, 8'h7C, 32'h0000_0405);
    repeat (20) @(posedge core_clk);
    check({chanMainOut[0], chanCompOut[0]}, 2'b00);
    check(overlapSeen, 1'b0);
    $display("test outputs finished");
    bus(1, 8'h84, 32'h0000_0100);
    bus(1, 8'h78, 32'h0100_0000);
    bus(0, 8'h78, 32'h0);
    check(rd, cfg);
    bus(1, 8'h7C, 32'h8000_0CFF);
    bus(0, 8'h7C, 32'h0);
    check(rd, 32'h0000_0C05);
    do_reset();
    bus(0, 8'h7C, 32'h0);
    check(rd, 32'h0000_0000);
    bus(0, 8'h80, 32'h0);
    check(rd, 32'h0000_0000);
    bus(1, 8'h84, 32'h0000_0200);
    bus(1, 8'h7C, 32'h0000_0C00);
    bus(0, 8'h7C, 32'h0);
    check(rd, 32'h0000_0000);
    bus(0, 8'h90, 32'h0);
    check({rsp, rd}, {2'b11, 32'h0});
    $display("test lock finished");
    give_verdict();
  end
endmodule : break_filter_and_deadtime_protect_tb
`default_nettype wire
